// [bdc_pkg.sv]
// Constants, field layouts and carrier types of the breakpoint debug control block.
// Assumes one core clock and an AXI4-Lite master for the debug registers.
// Summary of operation
// RL1: Each breakpoint has its own two-bit size field choosing one, two or four bytes.
// RL2: Size sets which low address bits compare; regions are naturally aligned.
// RL3: Each breakpoint has its own two-bit access-type field.
// RL4: Type 00 execution only, 01 data writes only, 11 data reads and writes.
// RL5: Software never programs access type 10; it never matches here.
// RL6: Execution breakpoints use the instruction start address, type 00, size 00.
// RL7: Enabled execution hit raises debug exception 1 as fault before execution.
// RL8: Software writes the watched linear address into a breakpoint address register.
// RL9: Debug registers open only in real mode or privilege level 0.
// RL10: While the guard bit is set every debug register access is blocked.
// RL11: Data breakpoints always match exactly, whatever the exact-match bits say.
// RL12: Data breakpoint trap is reported after the causing instruction completes.
// RL13: Next instruction is held until current data operand transfers complete.
// RL14: Task switch clears the per-task exact-match bit.
// RL15: Task switch leaves the system-wide exact-match bit unchanged.
// RL16: Execution breakpoints are always reported, independent of exact-match bits.
// RL17: A breakpoint is enabled by its global or local bit; hits invoke exception 1.
// RL18: Status register holds one flag per event that raises exception 1.
// RL19: After reset all four breakpoints are disabled.
// RL20: Four 32-bit linear addresses are compared continuously with generated addresses.
// RL21: Size 00 one byte, 01 two bytes, 11 four bytes; 10 unsupported.
package bdc_pkg;

  // ==========================================================================
  // Geometry
  localparam int          BDC_NUM_BP     = 4;
  localparam int          BDC_AXI_AW     = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0]  BDC_OFF_BP0    = 8'h00;
  localparam logic [7:0]  BDC_BP_STRIDE  = 8'h04;
  localparam logic [7:0]  BDC_OFF_STAT   = 8'h10;
  localparam logic [7:0]  BDC_OFF_CTRL   = 8'h14;

  // ==========================================================================
  // Control register fields
  localparam int          BDC_CTL_LOCAL0 = 0;
  localparam int          BDC_CTL_GLOB0  = 1;
  localparam int          BDC_CTL_TASKX  = 8;
  localparam int          BDC_CTL_SYSX   = 9;
  localparam int          BDC_CTL_GUARD  = 13;
  localparam int          BDC_CTL_TYPE0  = 16;
  localparam int          BDC_CTL_SIZE0  = 18;
  localparam int          BDC_CTL_FSTEP  = 4;
  localparam logic [31:0] BDC_CTL_WMASK  = 32'hffff23ff;
  localparam logic [31:0] BDC_CTL_RESET  = 32'h00000000;

  // ==========================================================================
  // Status register fields
  localparam int          BDC_STS_GUARD  = 13;
  localparam logic [31:0] BDC_STS_W1C    = 32'h0000200f;
  localparam logic [31:0] BDC_STS_RESET  = 32'h00000000;
  localparam logic [31:0] BDC_BP_RESET   = 32'h00000000;

  // ==========================================================================
  // Encodings
  localparam logic [1:0]  BDC_TYPE_EXEC  = 2'h0;
  localparam logic [1:0]  BDC_TYPE_WR    = 2'h1;
  localparam logic [1:0]  BDC_TYPE_RW    = 2'h3;
  localparam logic [1:0]  BDC_SIZE_1     = 2'h0;
  localparam logic [1:0]  BDC_SIZE_2     = 2'h1;
  localparam logic [1:0]  BDC_SIZE_4     = 2'h3;
  localparam logic [1:0]  BDC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  BDC_RESP_SLV   = 2'h2;
  localparam logic [1:0]  BDC_RESP_DEC   = 2'h3;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  len;
    logic        wr;
  } bdc_acc_t;

  typedef enum logic [1:0] {
    BDC_CH_IDLE = 2'b01,
    BDC_CH_RESP = 2'b10
  } bdc_ch_state_t;

endpackage

// [bdc_addr_match.sv]
// Byte-exact compare of one breakpoint region against one access.
// Assumes the access does not cross a doubleword boundary.
`timescale 1ns/1ps
module bdc_addr_match (
  // Breakpoint
  input  wire logic [31:0] bp_addr,
  input  wire logic [1:0]  bp_size,
  // Access
  input  wire logic [31:0] acc_addr,
  input  wire logic [1:0]  acc_len,
  // Result
  output logic             hit
);

  // ==========================================================================
  // Byte lanes covered inside the doubleword
  function automatic logic [3:0] lanes(input logic [1:0] lo, input logic [1:0] size);
    logic [3:0] m;
    m = 4'h0;
    if (size == bdc_pkg::BDC_SIZE_1) begin
      m = 4'h1 << lo;
    end else if (size == bdc_pkg::BDC_SIZE_2) begin
      m = 4'h3 << {lo[1], 1'b0};
    end else if (size == bdc_pkg::BDC_SIZE_4) begin
      m = 4'hf;
    end
    return m;
  endfunction

  wire logic [3:0] bp_lanes;
  wire logic [3:0] acc_lanes;

  assign bp_lanes  = lanes(bp_addr[1:0], bp_size); // RL1 RL2 RL21
  assign acc_lanes = lanes(acc_addr[1:0], acc_len);
  assign hit       = (bp_addr[31:2] == acc_addr[31:2]) & (|(bp_lanes & acc_lanes)); // RL11 RL20

endmodule

// [bdc_top.sv]
// Breakpoint debug control: four address breakpoints, control and status registers.
// Assumes an AXI4-Lite master and an execution unit that reports fetches and data accesses.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module bdc_top (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Processor mode
  input  wire logic                 cpu_real_mode,
  input  wire logic [1:0]           cpu_cpl,
  // Execution unit events
  input  wire logic                 fetch_valid,
  input  wire logic [31:0]          fetch_addr,
  input  wire logic                 data_valid,
  input  wire bdc_pkg::bdc_acc_t    data_acc,
  input  wire logic                 data_busy,
  input  wire logic                 insn_done,
  input  wire logic                 task_switch,
  // Debug exception
  output logic                      dbg_fault,
  output logic                      dbg_trap,
  output logic                      hold_next
);

  // ==========================================================================
  // State
  logic [31:0]                bp_ff [bdc_pkg::BDC_NUM_BP];
  logic [31:0]                ctrl_ff;
  logic [31:0]                stat_ff;
  logic [3:0]                 pend_ff;
  logic                       fault_ff;
  logic                       trap_ff;
  logic                       hold_ff;
  bdc_pkg::bdc_ch_state_t     wr_st_ff;
  bdc_pkg::bdc_ch_state_t     rd_st_ff;
  logic                       aw_got_ff;
  logic                       w_got_ff;
  logic [7:0]                 awaddr_ff;
  logic [31:0]                wdata_ff;
  logic [3:0]                 wstrb_ff;
  logic                       awready_ff;
  logic                       wready_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       arready_ff;
  logic                       rvalid_ff;
  logic [1:0]                 rresp_ff;
  logic [31:0]                rdata_ff;
  logic [31:0]                nxt_ctrl;
  logic [31:0]                nxt_stat;

  // ==========================================================================
  // Write channel decode
  wire logic                  aw_hs;
  wire logic                  w_hs;
  wire logic                  aw_got_n;
  wire logic                  w_got_n;
  wire logic                  wr_do;
  wire logic [7:0]            wa;
  wire logic [31:0]           wd;
  wire logic [3:0]            ws;
  wire logic [31:0]           wbits;
  wire logic [3:0]            wr_sel_bp;
  wire logic                  wr_sel_ctrl;
  wire logic                  wr_sel_stat;
  wire logic                  wr_map;
  wire logic                  priv_ok;
  wire logic                  guard;
  wire logic                  wr_ok;
  wire logic [1:0]            wr_resp;

  assign aw_hs       = s_axi_awvalid & awready_ff;
  assign w_hs        = s_axi_wvalid & wready_ff;
  assign aw_got_n    = aw_got_ff | aw_hs;
  assign w_got_n     = w_got_ff | w_hs;
  assign wr_do       = (wr_st_ff == bdc_pkg::BDC_CH_IDLE) & aw_got_n & w_got_n;
  assign wa          = aw_hs ? s_axi_awaddr : awaddr_ff;
  assign wd          = w_hs ? s_axi_wdata : wdata_ff;
  assign ws          = w_hs ? s_axi_wstrb : wstrb_ff;
  assign wbits       = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  assign wr_sel_ctrl = (wa == bdc_pkg::BDC_OFF_CTRL);
  assign wr_sel_stat = (wa == bdc_pkg::BDC_OFF_STAT);
  assign wr_map      = (|wr_sel_bp) | wr_sel_ctrl | wr_sel_stat;
  assign priv_ok     = cpu_real_mode | (cpu_cpl == 2'h0); // RL9
  assign guard       = ctrl_ff[bdc_pkg::BDC_CTL_GUARD];
  assign wr_ok       = wr_do & wr_map & priv_ok & ~guard; // RL9 RL10
  assign wr_resp     = !wr_map ? bdc_pkg::BDC_RESP_DEC :
                       (!priv_ok | guard) ? bdc_pkg::BDC_RESP_SLV : bdc_pkg::BDC_RESP_OKAY;

  // ==========================================================================
  // Read channel decode
  wire logic                  ar_hs;
  wire logic [31:0]           rd_val;
  wire logic                  rd_map;
  wire logic                  rd_ok;
  wire logic [1:0]            rd_resp;
  wire logic [3:0]            rd_sel_bp;
  wire logic                  guard_viol;

  assign ar_hs      = s_axi_arvalid & arready_ff;
  assign rd_map     = (|rd_sel_bp) | (s_axi_araddr == bdc_pkg::BDC_OFF_CTRL) |
                      (s_axi_araddr == bdc_pkg::BDC_OFF_STAT);
  assign rd_ok      = rd_map & priv_ok & ~guard; // RL9 RL10
  assign rd_resp    = !rd_map ? bdc_pkg::BDC_RESP_DEC :
                      rd_ok ? bdc_pkg::BDC_RESP_OKAY : bdc_pkg::BDC_RESP_SLV;
  assign rd_val     = !rd_ok ? 32'h00000000 :
                      rd_sel_bp[0] ? bp_ff[0] :
                      rd_sel_bp[1] ? bp_ff[1] :
                      rd_sel_bp[2] ? bp_ff[2] :
                      rd_sel_bp[3] ? bp_ff[3] :
                      (s_axi_araddr == bdc_pkg::BDC_OFF_CTRL) ? ctrl_ff : stat_ff;
  // Guard trips on any access attempt, mapped or not
  assign guard_viol = guard & (wr_do | ar_hs); // RL10

  // ==========================================================================
  // Per-breakpoint compare and registers
  wire logic [3:0]            f_hit;
  wire logic [3:0]            d_hit;

  for (genvar gi = 0; gi < bdc_pkg::BDC_NUM_BP; gi++) begin : g_bp
    wire logic [1:0] bp_type;
    wire logic [1:0] bp_size;
    wire logic       bp_en;
    wire logic       f_match;
    wire logic       d_match;
    wire logic [7:0] bp_off;

    assign bp_off  = bdc_pkg::BDC_OFF_BP0 + 8'(gi) * bdc_pkg::BDC_BP_STRIDE;
    assign bp_type = ctrl_ff[bdc_pkg::BDC_CTL_TYPE0 + gi * bdc_pkg::BDC_CTL_FSTEP +: 2]; // RL3
    assign bp_size = ctrl_ff[bdc_pkg::BDC_CTL_SIZE0 + gi * bdc_pkg::BDC_CTL_FSTEP +: 2]; // RL1
    assign bp_en   = ctrl_ff[bdc_pkg::BDC_CTL_LOCAL0 + 2 * gi] |
                     ctrl_ff[bdc_pkg::BDC_CTL_GLOB0 + 2 * gi]; // RL17
    assign wr_sel_bp[gi] = (wa == bp_off);
    assign rd_sel_bp[gi] = (s_axi_araddr == bp_off);

    bdc_addr_match u_fetch (
      .bp_addr  (bp_ff[gi]),
      .bp_size  (bp_size),
      .acc_addr (fetch_addr),
      .acc_len  (bdc_pkg::BDC_SIZE_1),
      .hit      (f_match)
    );

    bdc_addr_match u_data (
      .bp_addr  (bp_ff[gi]),
      .bp_size  (bp_size),
      .acc_addr (data_acc.addr),
      .acc_len  (data_acc.len),
      .hit      (d_match)
    );

    // Exact-match bits play no part in either compare
    assign f_hit[gi] = fetch_valid & bp_en & (bp_type == bdc_pkg::BDC_TYPE_EXEC) & f_match; // RL4 RL7 RL16
    assign d_hit[gi] = data_valid & bp_en & d_match &
                       (((bp_type == bdc_pkg::BDC_TYPE_WR) & data_acc.wr) |
                        (bp_type == bdc_pkg::BDC_TYPE_RW)); // RL4 RL5 RL11

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        bp_ff[gi] <= bdc_pkg::BDC_BP_RESET;
      end else if (wr_ok & wr_sel_bp[gi]) begin
        bp_ff[gi] <= (bp_ff[gi] & ~wbits) | (wd & wbits); // RL20
      end
    end
  end

  // ==========================================================================
  // Control and status next values
  wire logic [3:0]            done_hits;

  assign done_hits = insn_done ? (pend_ff | d_hit) : 4'h0;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ok & wr_sel_ctrl) begin
      nxt_ctrl = ((ctrl_ff & ~wbits) | (wd & wbits)) & bdc_pkg::BDC_CTL_WMASK;
    end
    if (task_switch) begin
      nxt_ctrl[bdc_pkg::BDC_CTL_TASKX] = 1'b0; // RL14 RL15
    end
    // Guard drops so the handler can reach the registers
    if (guard_viol) begin
      nxt_ctrl[bdc_pkg::BDC_CTL_GUARD] = 1'b0;
    end
  end

  always_comb begin
    nxt_stat = stat_ff;
    if (wr_ok & wr_sel_stat) begin
      nxt_stat = stat_ff & ~(wd & wbits & bdc_pkg::BDC_STS_W1C);
    end
    // Sets after the clear so a same-cycle event survives
    nxt_stat[3:0] = nxt_stat[3:0] | f_hit | done_hits; // RL18
    if (guard_viol) begin
      nxt_stat[bdc_pkg::BDC_STS_GUARD] = 1'b1; // RL18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= bdc_pkg::BDC_CTL_RESET; // RL19
      stat_ff  <= bdc_pkg::BDC_STS_RESET;
      pend_ff  <= 4'h0;
      fault_ff <= 1'b0;
      trap_ff  <= 1'b0;
      hold_ff  <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      stat_ff  <= nxt_stat;
      pend_ff  <= insn_done ? 4'h0 : (pend_ff | d_hit);
      fault_ff <= (|f_hit) | guard_viol; // RL7
      trap_ff  <= |done_hits; // RL12
      hold_ff  <= data_valid | data_busy; // RL13
    end
  end

  // ==========================================================================
  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff   <= bdc_pkg::BDC_CH_IDLE;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= bdc_pkg::BDC_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      case (wr_st_ff)
        bdc_pkg::BDC_CH_IDLE: begin
          if (wr_do) begin
            wr_st_ff   <= bdc_pkg::BDC_CH_RESP;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_resp; // RL9 RL10
          end else begin
            aw_got_ff  <= aw_got_n;
            w_got_ff   <= w_got_n;
            awready_ff <= ~aw_got_n;
            wready_ff  <= ~w_got_n;
          end
        end
        bdc_pkg::BDC_CH_RESP: begin
          if (s_axi_bready) begin
            wr_st_ff   <= bdc_pkg::BDC_CH_IDLE;
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
          end
        end
        default: begin
          wr_st_ff <= bdc_pkg::BDC_CH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_ff   <= bdc_pkg::BDC_CH_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= bdc_pkg::BDC_RESP_OKAY;
      rdata_ff   <= 32'h00000000;
    end else begin
      case (rd_st_ff)
        bdc_pkg::BDC_CH_IDLE: begin
          if (ar_hs) begin
            rd_st_ff   <= bdc_pkg::BDC_CH_RESP;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rresp_ff   <= rd_resp;
            rdata_ff   <= rd_val;
          end else begin
            arready_ff <= 1'b1;
          end
        end
        bdc_pkg::BDC_CH_RESP: begin
          if (s_axi_rready) begin
            rd_st_ff   <= bdc_pkg::BDC_CH_IDLE;
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
          end
        end
        default: begin
          rd_st_ff <= bdc_pkg::BDC_CH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign dbg_fault     = fault_ff;
  assign dbg_trap      = trap_ff;
  assign hold_next     = hold_ff;

  // ==========================================================================
  // Checks
  property p_reset_off;
    @(posedge aclk) !aresetn |=> (ctrl_ff[7:0] == 8'h00);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enables not clear after reset"); // RL19

  property p_exec_fault;
    @(posedge aclk) disable iff (!aresetn)
      (fetch_valid && (|f_hit)) |=> (dbg_fault && (|(stat_ff[3:0] & $past(f_hit))));
  endproperty
  a_exec_fault: assert property (p_exec_fault) else $error("execution hit gave no fault"); // RL7

  property p_trap_after_done;
    @(posedge aclk) disable iff (!aresetn) dbg_trap |-> $past(insn_done);
  endproperty
  a_trap_after_done: assert property (p_trap_after_done) else $error("trap before completion"); // RL12

  property p_task_clear;
    @(posedge aclk) disable iff (!aresetn)
      task_switch |=> !ctrl_ff[bdc_pkg::BDC_CTL_TASKX];
  endproperty
  a_task_clear: assert property (p_task_clear) else $error("task exact bit survived"); // RL14

  property p_sys_keep;
    @(posedge aclk) disable iff (!aresetn)
      (task_switch && !(wr_ok && wr_sel_ctrl)) |=>
      (ctrl_ff[bdc_pkg::BDC_CTL_SYSX] == $past(ctrl_ff[bdc_pkg::BDC_CTL_SYSX]));
  endproperty
  a_sys_keep: assert property (p_sys_keep) else $error("system exact bit changed"); // RL15

  property p_guard_block;
    @(posedge aclk) disable iff (!aresetn)
      (wr_do && guard && wr_map) |=> (s_axi_bvalid && (s_axi_bresp == bdc_pkg::BDC_RESP_SLV)
                                      && (ctrl_ff[31:14] == $past(ctrl_ff[31:14])));
  endproperty
  a_guard_block: assert property (p_guard_block) else $error("guarded write accepted"); // RL10

  property p_priv_block;
    @(posedge aclk) disable iff (!aresetn)
      (ar_hs && rd_map && !priv_ok) |=> (s_axi_rvalid && (s_axi_rresp == bdc_pkg::BDC_RESP_SLV)
                                          && (s_axi_rdata == 32'h00000000));
  endproperty
  a_priv_block: assert property (p_priv_block) else $error("unprivileged read answered"); // RL9

  property p_guard_flag;
    @(posedge aclk) disable iff (!aresetn)
      guard_viol |=> (stat_ff[bdc_pkg::BDC_STS_GUARD] && dbg_fault && !guard);
  endproperty
  a_guard_flag: assert property (p_guard_flag) else $error("guard event not flagged"); // RL18

  property p_hold;
    @(posedge aclk) disable iff (!aresetn) (data_valid || data_busy) |=> hold_next;
  endproperty
  a_hold: assert property (p_hold) else $error("next instruction not held"); // RL13

  property p_disabled_quiet;
    @(posedge aclk) disable iff (!aresetn)
      ((ctrl_ff[7:0] == 8'h00) && !guard_viol) |=> !dbg_fault;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("fault while disabled"); // RL17

endmodule

// [bdc_cpu_model.sv]
// Execution unit stand-in: fetches, data accesses and task switches on command.
// Assumes commands arrive one cycle long from the bench, right after a rising edge.
`timescale 1ns/1ps
module bdc_cpu_model (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Command: 1 fetch, 2 data access, 3 task switch
  input  wire logic [1:0]        cmd,
  input  wire logic [31:0]       cmd_addr,
  input  wire logic [1:0]        cmd_len,
  input  wire logic              cmd_wr,
  // Execution unit events
  output logic                   fetch_valid,
  output logic [31:0]            fetch_addr,
  output logic                   data_valid,
  output bdc_pkg::bdc_acc_t      data_acc,
  output logic                   data_busy,
  output logic                   insn_done,
  output logic                   task_switch
);
  initial fetch_addr = '0;
  initial data_acc = '0;
  // Idle address lines toggle so stale values never look valid
  always @(posedge aclk) begin
    fetch_valid <= aresetn && cmd == 2'h1;
    fetch_addr  <= (cmd == 2'h1) ? cmd_addr : ~fetch_addr;
    data_valid  <= aresetn && cmd == 2'h2;
    data_acc    <= (cmd == 2'h2) ? {cmd_addr, cmd_len, cmd_wr} : ~data_acc;
    data_busy   <= aresetn && data_valid;
    insn_done   <= aresetn && data_busy;
    task_switch <= aresetn && cmd == 2'h3;
  end
endmodule

// [breakpoint_debug_control_test.sv]
// Self-checking bench of the breakpoint debug control block.
// Assumes an AXI4-Lite master and the execution unit model around it.
`timescale 1ns/1ps
module breakpoint_debug_control_test;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, cmd_addr = 0;
  logic real_m = 1, cmd_wr = 0, prev = 0, pdone = 0;
  logic [1:0] cpl = 0, cmd = 0, cmd_len = 0;
  wire awready, wready, bvalid, arready, rvalid, fv, dv, db, idone, tsw, fault, trap, hold;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, faddr;
  wire bdc_pkg::bdc_acc_t acc;
  int failures = 0, checks = 0, nf = 0, nt = 0, et = 0, seed = 23;
  always #50 aclk = ~aclk;
  bdc_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_wr(cmd_wr), .fetch_valid(fv), .fetch_addr(faddr), .data_valid(dv),
    .data_acc(acc), .data_busy(db), .insn_done(idone), .task_switch(tsw));
  bdc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_real_mode(real_m), .cpu_cpl(cpl), .fetch_valid(fv), .fetch_addr(faddr),
    .data_valid(dv), .data_acc(acc), .data_busy(db), .insn_done(idone), .task_switch(tsw),
    .dbg_fault(fault), .dbg_trap(trap), .hold_next(hold));
  // ==========================================================================
  // Checking helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic exp_hit(input logic [31:0] b, input logic [31:0] a,
                                   input logic [1:0] sz, input logic [1:0] ty,
                                   input logic [1:0] ln, input logic w);
    logic [31:0] s;
    s = b & ~{30'h0, sz};
    return (ty == 2'h3 || (ty == 2'h1 && w)) && a <= s + sz && s <= a + ln;
  endfunction
  always @(posedge aclk) begin
    nf <= nf + (aresetn && fault !== 1'b0);
    nt <= nt + (aresetn && trap !== 1'b0);
    prev <= aresetn && (dv || db);
    pdone <= idone;
    if (aresetn) chk("hold_next", prev, hold);
    if (trap === 1'b1) chk("trap_after_done", 1, pdone);
  end
  // ==========================================================================
  // Bus and event tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    repeat (40) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) begin
        bready <= 0;
        chk("bresp", er, bresp);
        @(posedge aclk);
        return;
      end
    end
    failures++;
    end_sim;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    repeat (40) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) begin
        rready <= 0;
        chk("rresp", er, rresp);
        chk("rdata", ed, rdata);
        @(posedge aclk);
        return;
      end
    end
    failures++;
    end_sim;
  endtask
  task automatic op(input logic [1:0] c, input logic [31:0] a, input logic [1:0] l,
                    input logic w);
    cmd <= c;
    cmd_addr <= a;
    cmd_len <= l;
    cmd_wr <= w;
    @(posedge aclk);
    cmd <= 0;
    repeat (6) @(posedge aclk);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    logic [31:0] b, a, r;
    logic [1:0] sz, ty, ln;
    logic h;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h14, 0, 0);
    rd(8'h10, 0, 0);
    op(1, 0, 0, 0);
    chk("fault", 0, nf);
    b = $random(seed);
    wr(8'h00, b, 0);
    wr(8'h14, 32'h00000301, 0);
    op(1, b + 1, 0, 0);
    chk("fault", 0, nf);
    op(1, b, 0, 0);
    chk("fault", 1, nf);
    rd(8'h10, 0, 1);
    wr(8'h10, 32'h0000000f, 0);
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      b = r & 32'h0ffffff0;
      sz = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
      ty = (i < 6) ? 2'h1 : 2'h3;
      ln = {r[1], r[1] | r[0]};
      a = ((b & ~32'h7) + {29'h0, r[6:4]}) & ~{30'h0, ln};
      b = b + {29'h0, r[10:8]};
      wr(8'h04, b, 0);
      wr(8'h14, {8'h0, sz, ty, 10'h0, r[13:12], 8'h08}, 0);
      h = exp_hit(b, a, sz, ty, ln, r[16]);
      et += h;
      op(2, a, ln, r[16]);
      chk("trap", et, nt);
      rd(8'h10, 0, {30'h0, h, 1'b0});
      wr(8'h10, 32'h0000000f, 0);
    end
    wr(8'h14, 32'h00000300, 0);
    op(3, 0, 0, 0);
    rd(8'h14, 0, 32'h00000200);
    real_m <= 0;
    cpl <= 3;
    rd(8'h14, 2, 0);
    real_m <= 1;
    rd(8'h14, 0, 32'h00000200);
    wr(8'h14, 32'h00002200, 0);
    rd(8'h14, 2, 0);
    rd(8'h10, 0, 32'h00002000);
    rd(8'h14, 0, 32'h00000200);
    wr(8'h14, 32'h00002200, 0);
    wr(8'h14, 32'h00000000, 2);
    rd(8'h14, 0, 32'h00000200);
    chk("fault", 3, nf);
    rd(8'h18, 3, 0);
    end_sim;
  end
endmodule
